// *** rtl/qpm_pkg.sv ***
`default_nettype none

package qpm_pkg;

  // Port count and data path widths
  localparam int NPORT = 4;
  localparam int AW = 16;
  localparam int DW = 18;

  // Address bits compared for a mailbox hit, deep and half-deep array
  localparam int MBX_MATCH_64K = 16;
  localparam int MBX_MATCH_32K = 15;

  // Captured control vector, one bit per pin
  localparam int CTL_W = 9;
  localparam int CTL_RW = 0;
  localparam int CTL_SEL_N = 1;
  localparam int CTL_SEL_HI = 2;
  localparam int CTL_LOAD_N = 3;
  localparam int CTL_ADV_N = 4;
  localparam int CTL_MASK_LOAD_N_N = 5;
  localparam int CTL_OE_N = 6;
  localparam int CTL_BE_LO_N = 7;
  localparam int CTL_BE_HI_N = 8;
  localparam int LO_BYTE_W = 9;

  typedef logic [AW-1:0] qpm_addr_t;
  typedef logic [DW-1:0] qpm_word_t;
  typedef logic [CTL_W-1:0] qpm_ctl_t;

  // Values after reset: deselected controls, cleared counter, open mask
  localparam qpm_ctl_t CTL_IDLE = 9'h1fb;
  localparam qpm_addr_t CNT_RESET = 16'h0000;
  localparam qpm_addr_t MASK_RESET = 16'hffff;
  localparam qpm_word_t WORD_RESET = 18'h00000;
  localparam logic IRQ_IDLE = 1'b1;

endpackage

`default_nettype wire

// *** rtl/qpm_port_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// One port's captured access, valid in the cycle that tick is high
interface qpm_port_if;
  logic tick;
  qpm_pkg::qpm_addr_t addr;
  qpm_pkg::qpm_word_t wdata;
  qpm_pkg::qpm_ctl_t ctl;

  modport src (output tick, output addr, output wdata, output ctl);
  modport dst (input tick, input addr, input wdata, input ctl);
endinterface

`default_nettype wire

// *** rtl/qpm_port_front.sv ***
`timescale 1ns/10ps
`default_nettype none

module qpm_port_front (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic port_clk_i,
  input wire qpm_pkg::qpm_addr_t addr_i,
  input wire qpm_pkg::qpm_word_t wdata_i,
  input wire qpm_pkg::qpm_ctl_t ctl_i,
  qpm_port_if.src port_o
);
  import qpm_pkg::*;

  localparam int BUS_W = 1 + AW + DW + CTL_W;
  localparam logic [BUS_W-1:0] BUS_IDLE = {CTL_IDLE, WORD_RESET, CNT_RESET, 1'b0};

  logic [BUS_W-1:0] s1_reg;
  logic [BUS_W-1:0] s2_reg;
  logic [BUS_W-1:0] s3_reg;
  logic clk_lvl_reg;
  logic clk_agree;
  logic rise;

  // Clock and pins share one pipe so the fields stay aligned with the edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_reg <= BUS_IDLE;
      s2_reg <= BUS_IDLE;
      s3_reg <= BUS_IDLE;
    end else begin
      s1_reg <= {ctl_i, wdata_i, addr_i, port_clk_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A clock level counts only once two stages agree
  assign clk_agree = (s2_reg[0] == s3_reg[0]);
  assign rise = clk_agree && s3_reg[0] && !clk_lvl_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      clk_lvl_reg <= 1'b0;
    end else if (clk_agree) begin
      clk_lvl_reg <= s3_reg[0];
    end
  end

  // Inputs are registered on the port's rising edge only
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      port_o.tick <= 1'b0;
      port_o.addr <= CNT_RESET;
      port_o.wdata <= WORD_RESET;
      port_o.ctl <= CTL_IDLE;
    end else begin
      port_o.tick <= rise;
      if (rise) begin
        port_o.addr <= s3_reg[AW:1];
        port_o.wdata <= s3_reg[AW+DW:AW+1];
        port_o.ctl <= s3_reg[BUS_W-1:AW+DW+1];
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/qpm_mailbox_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module qpm_mailbox_top #(
  parameter int MATCH_W = qpm_pkg::MBX_MATCH_64K
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic global_reset_n_i,
  input wire logic [qpm_pkg::NPORT-1:0] port_clk_i,
  input wire qpm_pkg::qpm_addr_t [qpm_pkg::NPORT-1:0] port_addr_i,
  input wire qpm_pkg::qpm_word_t [qpm_pkg::NPORT-1:0] port_wdata_i,
  input wire logic [qpm_pkg::NPORT-1:0] port_rw_i,
  input wire logic [qpm_pkg::NPORT-1:0] select_active_low_n_i,
  input wire logic [qpm_pkg::NPORT-1:0] select_active_high_i,
  input wire logic [qpm_pkg::NPORT-1:0] count_load_n_i,
  input wire logic [qpm_pkg::NPORT-1:0] count_advance_n_i,
  input wire logic [qpm_pkg::NPORT-1:0] mask_load_n_i,
  input wire logic [qpm_pkg::NPORT-1:0] port_oe_n_i,
  input wire logic [qpm_pkg::NPORT-1:0] lower_byte_en_n_i,
  input wire logic [qpm_pkg::NPORT-1:0] upper_byte_en_n_i,
  output logic [qpm_pkg::NPORT-1:0] mbx_irq_n_o,
  output logic [qpm_pkg::NPORT-1:0] wrap_irq_n_o,
  output qpm_pkg::qpm_word_t [qpm_pkg::NPORT-1:0] mbx_rdata_o,
  output logic [qpm_pkg::NPORT-1:0] mbx_rdata_lo_oe_o,
  output logic [qpm_pkg::NPORT-1:0] mbx_rdata_hi_oe_o,
  output logic [qpm_pkg::NPORT-1:0] port_awake_o,
  output qpm_pkg::qpm_addr_t [qpm_pkg::NPORT-1:0] count_addr_o
);
  import qpm_pkg::*;

  localparam qpm_addr_t MATCH_MASK = AW'((32'd1 << MATCH_W) - 32'd1);

  // Global reset pin synchroniser and accepted level
  logic gr_s1_reg;
  logic gr_s2_reg;
  logic gr_s3_reg;
  logic gr_lvl_reg;
  logic sys_rst_n;

  // Per-port captured access and derived events
  qpm_ctl_t [NPORT-1:0] ctl_in;
  logic [NPORT-1:0] tick;
  qpm_addr_t [NPORT-1:0] cap_addr;
  qpm_word_t [NPORT-1:0] cap_wdata;
  qpm_ctl_t [NPORT-1:0] cap_ctl;
  logic [NPORT-1:0] sel;
  logic [NPORT-1:0] wr_ev;
  logic [NPORT-1:0] rd_ev;
  logic [NPORT-1:0] set_ev;
  logic [NPORT-1:0] clr_ev;
  logic [NPORT-1:0] wrap_hit;
  logic [NPORT-1:0] rd_mbx;
  qpm_addr_t [NPORT-1:0] eff_addr;
  qpm_addr_t [NPORT-1:0] inc_addr;
  qpm_word_t rd_word [NPORT];

  // Block state
  qpm_addr_t cnt_reg [NPORT];
  qpm_addr_t mask_reg [NPORT];
  qpm_word_t mbx_word_reg [NPORT];
  logic [NPORT-1:0] flag_n_reg;
  logic [NPORT-1:0] wrap_n_reg;
  logic [NPORT-1:0] awake_reg;
  qpm_word_t [NPORT-1:0] rdata_reg;
  logic [NPORT-1:0] lo_oe_reg;
  logic [NPORT-1:0] hi_oe_reg;

  // Mailbox of port idx sits idx below the top of the compared range
  function automatic logic mbx_hit(input qpm_addr_t a, input int idx);
    return ((a ^ ~AW'(idx)) & MATCH_MASK) == CNT_RESET;
  endfunction

  // Unmasked bits count as one concatenated field; masked bits hold
  function automatic qpm_addr_t masked_inc(input qpm_addr_t c, input qpm_addr_t m);
    qpm_addr_t carry;
    carry = (c | ~m) + 16'h0001;
    return (carry & m) | (c & ~m);
  endfunction

  // Global reset takes effect on the reference clock, never a port clock
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gr_s1_reg <= 1'b1;
      gr_s2_reg <= 1'b1;
      gr_s3_reg <= 1'b1;
      gr_lvl_reg <= 1'b1;
    end else begin
      gr_s1_reg <= global_reset_n_i;
      gr_s2_reg <= gr_s1_reg;
      gr_s3_reg <= gr_s2_reg;
      if (gr_s2_reg == gr_s3_reg) begin
        gr_lvl_reg <= gr_s3_reg;
      end
    end
  end

  assign sys_rst_n = rst_n_i && gr_lvl_reg;

  qpm_port_if pif [NPORT] ();

  // One synchronising front end per port clock
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    assign ctl_in[i] = {upper_byte_en_n_i[i], lower_byte_en_n_i[i], port_oe_n_i[i],
                        mask_load_n_i[i], count_advance_n_i[i], count_load_n_i[i],
                        select_active_high_i[i], select_active_low_n_i[i], port_rw_i[i]};

    qpm_port_front u_front (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(sys_rst_n),
      .port_clk_i(port_clk_i[i]),
      .addr_i(port_addr_i[i]),
      .wdata_i(port_wdata_i[i]),
      .ctl_i(ctl_in[i]),
      .port_o(pif[i])
    );

    assign tick[i] = pif[i].tick;
    assign cap_addr[i] = pif[i].addr;
    assign cap_wdata[i] = pif[i].wdata;
    assign cap_ctl[i] = pif[i].ctl;
  end

  // Access decode; output and byte enables take no part here
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      sel[i] = !cap_ctl[i][CTL_SEL_N] && cap_ctl[i][CTL_SEL_HI];
      inc_addr[i] = masked_inc(cnt_reg[i], mask_reg[i]);
      if (!cap_ctl[i][CTL_LOAD_N]) begin
        eff_addr[i] = cap_addr[i];
      end else if (!cap_ctl[i][CTL_ADV_N]) begin
        eff_addr[i] = inc_addr[i];
      end else begin
        eff_addr[i] = cnt_reg[i];
      end
      wr_ev[i] = tick[i] && sel[i] && !cap_ctl[i][CTL_RW];
      rd_ev[i] = tick[i] && sel[i] && cap_ctl[i][CTL_RW];
      wrap_hit[i] = cap_ctl[i][CTL_LOAD_N] && !cap_ctl[i][CTL_ADV_N]
                    && (mask_reg[i] != CNT_RESET)
                    && ((inc_addr[i] & mask_reg[i]) == CNT_RESET);
    end
  end

  // Set comes only from other ports; clear only from the owner
  always_comb begin
    for (int t = 0; t < NPORT; t++) begin
      set_ev[t] = 1'b0;
      clr_ev[t] = rd_ev[t] && mbx_hit(eff_addr[t], t);
      for (int j = 0; j < NPORT; j++) begin
        if (j != t && wr_ev[j] && mbx_hit(eff_addr[j], t)) begin
          set_ev[t] = 1'b1;
        end
      end
    end
  end

  // Which mailbox word, if any, a read selects
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      rd_mbx[i] = 1'b0;
      rd_word[i] = WORD_RESET;
      for (int m = 0; m < NPORT; m++) begin
        if (mbx_hit(eff_addr[i], m)) begin
          rd_mbx[i] = 1'b1;
          rd_word[i] = mbx_word_reg[m];
        end
      end
    end
  end

  // Mailbox flags, one shared domain, so set and clear never race
  always_ff @(posedge ref_clk_i) begin
    if (!sys_rst_n) begin
      flag_n_reg <= {NPORT{IRQ_IDLE}};
    end else begin
      for (int t = 0; t < NPORT; t++) begin
        if (set_ev[t]) begin
          flag_n_reg[t] <= 1'b0;
        end else if (clr_ev[t]) begin
          flag_n_reg[t] <= 1'b1;
        end
      end
    end
  end

  // Address counter and mask, stepped on the port's own edge
  always_ff @(posedge ref_clk_i) begin
    if (!sys_rst_n) begin
      for (int i = 0; i < NPORT; i++) begin
        cnt_reg[i] <= CNT_RESET;
        mask_reg[i] <= MASK_RESET;
      end
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (tick[i]) begin
          if (!cap_ctl[i][CTL_LOAD_N]) begin
            cnt_reg[i] <= cap_addr[i];
          end else if (!cap_ctl[i][CTL_ADV_N]) begin
            cnt_reg[i] <= inc_addr[i];
          end
          if (!cap_ctl[i][CTL_MASK_LOAD_N_N]) begin
            mask_reg[i] <= cap_addr[i];
          end
        end
      end
    end
  end

  // Wrap pulse stays low for one port cycle, released at the next edge
  always_ff @(posedge ref_clk_i) begin
    if (!sys_rst_n) begin
      wrap_n_reg <= {NPORT{IRQ_IDLE}};
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (tick[i]) begin
          wrap_n_reg[i] <= !wrap_hit[i];
        end
      end
    end
  end

  // Mailbox storage; lowest port wins a collision in each byte lane it enables
  always_ff @(posedge ref_clk_i) begin
    if (!sys_rst_n) begin
      for (int m = 0; m < NPORT; m++) begin
        mbx_word_reg[m] <= WORD_RESET;
      end
    end else begin
      for (int m = 0; m < NPORT; m++) begin
        for (int j = NPORT - 1; j >= 0; j--) begin
          if (wr_ev[j] && mbx_hit(eff_addr[j], m)) begin
            if (!cap_ctl[j][CTL_BE_LO_N]) begin
              mbx_word_reg[m][LO_BYTE_W-1:0] <= cap_wdata[j][LO_BYTE_W-1:0];
            end
            if (!cap_ctl[j][CTL_BE_HI_N]) begin
              mbx_word_reg[m][DW-1:LO_BYTE_W] <= cap_wdata[j][DW-1:LO_BYTE_W];
            end
          end
        end
      end
    end
  end

  // Power state follows the enables sampled at each port edge
  always_ff @(posedge ref_clk_i) begin
    if (!sys_rst_n) begin
      awake_reg <= '0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (tick[i]) begin
          awake_reg[i] <= sel[i];
        end
      end
    end
  end

  // Read data path; a port woken this edge does not drive until the next
  always_ff @(posedge ref_clk_i) begin
    if (!sys_rst_n) begin
      rdata_reg <= '0;
      lo_oe_reg <= '0;
      hi_oe_reg <= '0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (tick[i]) begin
          if (rd_ev[i] && rd_mbx[i]) begin
            rdata_reg[i] <= rd_word[i];
          end
          lo_oe_reg[i] <= rd_ev[i] && rd_mbx[i] && awake_reg[i]
                          && !cap_ctl[i][CTL_OE_N] && !cap_ctl[i][CTL_BE_LO_N];
          hi_oe_reg[i] <= rd_ev[i] && rd_mbx[i] && awake_reg[i]
                          && !cap_ctl[i][CTL_OE_N] && !cap_ctl[i][CTL_BE_HI_N];
        end
      end
    end
  end

  // All outputs come straight from registers
  assign mbx_irq_n_o = flag_n_reg;
  assign wrap_irq_n_o = wrap_n_reg;
  assign mbx_rdata_o = rdata_reg;
  assign mbx_rdata_lo_oe_o = lo_oe_reg;
  assign mbx_rdata_hi_oe_o = hi_oe_reg;
  assign port_awake_o = awake_reg;
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      count_addr_o[i] = cnt_reg[i];
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!sys_rst_n);

  // Checks per port
  for (genvar k = 0; k < NPORT; k++) begin : g_chk
    flag_set_a: assert property (set_ev[k] |=> !mbx_irq_n_o[k])
      else $error("mailbox flag not set after foreign write");
    flag_clear_a: assert property (clr_ev[k] && !set_ev[k] ##1 !set_ev[k] |-> mbx_irq_n_o[k])
      else $error("mailbox flag not cleared by owner read");
    own_write_a: assert property ((tick == (NPORT'(1) << k)) && wr_ev[k] && mbx_hit(eff_addr[k], k)
      |=> $stable(mbx_irq_n_o[k]))
      else $error("own mailbox write changed the flag");
    wrap_pulse_a: assert property (tick[k] && wrap_hit[k] |=> !wrap_irq_n_o[k] until tick[k])
      else $error("wrap pulse missing or ended early");
    wrap_idle_a: assert property (tick[k] && !wrap_hit[k] |=> wrap_irq_n_o[k])
      else $error("wrap pulse without a wrap");
    awake_track_a: assert property (tick[k] ##1 1'b1 |-> port_awake_o[k] == $past(sel[k]))
      else $error("power state does not follow enables");
    drive_awake_a: assert property ($rose(mbx_rdata_lo_oe_o[k]) |-> $past(awake_reg[k], 2))
      else $error("output driven before wake-up cycle");
    keep_data_a: assert property (wr_ev[k] && mbx_hit(eff_addr[k], 0)
      && cap_ctl[k][CTL_BE_LO_N] && cap_ctl[k][CTL_BE_HI_N] && (wr_ev == (NPORT'(1) << k))
      |=> $stable(mbx_word_reg[0]))
      else $error("disabled byte lanes altered mailbox data");
  end

  reset_idle_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    !sys_rst_n |=> (mbx_irq_n_o == '1) && (wrap_irq_n_o == '1) && (count_addr_o[0] == CNT_RESET)
    && (mask_reg[0] == MASK_RESET))
    else $error("reset did not idle counters and interrupts");

  set_cov: cover property (set_ev[0] ##[1:200] clr_ev[0]);
  race_cov: cover property (set_ev[0] && clr_ev[0]);
  wrap_cov: cover property (tick[2] && wrap_hit[2]);
  multi_set_cov: cover property ($countones(wr_ev) > 1 && set_ev[0]);

endmodule

`default_nettype wire

// *** testbench/qpm_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module qpm_host_model (
  input wire logic ref_clk_i,
  output logic [qpm_pkg::NPORT-1:0] port_clk_o,
  output qpm_pkg::qpm_addr_t [qpm_pkg::NPORT-1:0] addr_o,
  output qpm_pkg::qpm_word_t [qpm_pkg::NPORT-1:0] wdata_o,
  output logic [qpm_pkg::NPORT-1:0] rw_o,
  output logic [qpm_pkg::NPORT-1:0] sel_n_o,
  output logic [qpm_pkg::NPORT-1:0] sel_hi_o,
  output logic [qpm_pkg::NPORT-1:0] load_n_o,
  output logic [qpm_pkg::NPORT-1:0] adv_n_o,
  output logic [qpm_pkg::NPORT-1:0] mask_load_n_o,
  output logic [qpm_pkg::NPORT-1:0] oe_n_o,
  output logic [qpm_pkg::NPORT-1:0] be_lo_n_o,
  output logic [qpm_pkg::NPORT-1:0] be_hi_n_o
);
  import qpm_pkg::*;

  // Idle hosts: deselected, counters held, mask never reloaded
  initial begin
    port_clk_o = '0;
    addr_o = '0;
    wdata_o = '0;
    rw_o = '1;
    sel_n_o = '1;
    sel_hi_o = '0;
    load_n_o = '1;
    adv_n_o = '1;
    mask_load_n_o = '1;
    oe_n_o = '1;
    be_lo_n_o = '1;
    be_hi_n_o = '1;
  end

  // Fields change only while the port clock stands low; sel 1 or 2 deselects
  task automatic setp(input int k, input qpm_addr_t a, input qpm_word_t d, input logic rd,
                      input int sel, input logic ld_n, input logic adv_n, input logic quiet);
    addr_o[k] = a;
    wdata_o[k] = d;
    rw_o[k] = rd;
    sel_n_o[k] = (sel == 1);
    sel_hi_o[k] = (sel != 2);
    load_n_o[k] = ld_n;
    adv_n_o[k] = adv_n;
    oe_n_o[k] = quiet;
    be_lo_n_o[k] = quiet;
    be_hi_n_o[k] = quiet;
  endtask

  // Pins settle four cycles before the edge and hold well after it, so a
  // later access never reads a word another port is still storing
  task automatic pulse(input logic [NPORT-1:0] m);
    repeat (4) @(posedge ref_clk_i);
    #2 port_clk_o = m;
    repeat (5) @(posedge ref_clk_i);
    #2 port_clk_o = '0;
    repeat (5) @(posedge ref_clk_i);
    #2;
  endtask
endmodule

`default_nettype wire

// *** testbench/qpm_mailbox_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module qpm_mailbox_top_tb;
  import qpm_pkg::*;
  logic ref_clk, rst_n, global_reset_n;
  logic [NPORT-1:0] pclk, rw, sel_n, sel_hi, ld_n, adv_n, mk_n, oe_n, be_lo_n, be_hi_n;
  qpm_addr_t [NPORT-1:0] addr, cnt;
  qpm_word_t [NPORT-1:0] wdata, rdata;
  logic [NPORT-1:0] irq_n, wrap_n, lo_oe, hi_oe, awake, irq_half;
  logic [NPORT-1:0] m_irq, m_wrap, m_awake, m_oe_lo, m_oe_hi;
  int m_cnt[NPORT], m_word[NPORT], m_rd[NPORT], m_mask[NPORT];
  int n_mismatch = 0;
  int samples_checked = 0;
  int unsigned seed = 16453;

  qpm_host_model h (.ref_clk_i(ref_clk), .port_clk_o(pclk), .addr_o(addr), .wdata_o(wdata),
    .rw_o(rw), .sel_n_o(sel_n), .sel_hi_o(sel_hi), .load_n_o(ld_n), .adv_n_o(adv_n),
    .mask_load_n_o(mk_n), .oe_n_o(oe_n), .be_lo_n_o(be_lo_n), .be_hi_n_o(be_hi_n));

  qpm_mailbox_top DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .global_reset_n_i(global_reset_n),
    .port_clk_i(pclk), .port_addr_i(addr), .port_wdata_i(wdata), .port_rw_i(rw),
    .select_active_low_n_i(sel_n), .select_active_high_i(sel_hi), .count_load_n_i(ld_n),
    .count_advance_n_i(adv_n), .mask_load_n_i(mk_n), .port_oe_n_i(oe_n),
    .lower_byte_en_n_i(be_lo_n), .upper_byte_en_n_i(be_hi_n), .mbx_irq_n_o(irq_n),
    .wrap_irq_n_o(wrap_n), .mbx_rdata_o(rdata), .mbx_rdata_lo_oe_o(lo_oe),
    .mbx_rdata_hi_oe_o(hi_oe), .port_awake_o(awake), .count_addr_o(cnt));

  // Half-deep part on the same pins; only its mailbox flags are watched
  qpm_mailbox_top #(.MATCH_W(MBX_MATCH_32K)) DUT_HALF (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .global_reset_n_i(global_reset_n), .port_clk_i(pclk), .port_addr_i(addr),
    .port_wdata_i(wdata), .port_rw_i(rw), .select_active_low_n_i(sel_n),
    .select_active_high_i(sel_hi), .count_load_n_i(ld_n), .count_advance_n_i(adv_n),
    .mask_load_n_i(mk_n), .port_oe_n_i(oe_n), .lower_byte_en_n_i(be_lo_n),
    .upper_byte_en_n_i(be_hi_n), .mbx_irq_n_o(irq_half), .wrap_irq_n_o(), .mbx_rdata_o(),
    .mbx_rdata_lo_oe_o(), .mbx_rdata_hi_oe_o(), .port_awake_o(), .count_addr_o());

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic qpm_addr_t mbx(input int j);
    return 16'hffff - 16'(j);
  endfunction

  // Unmasked bits form one counter; the carry skips over masked bits
  function automatic int step(input int c, input int msk);
    int cy;
    cy = 1;
    for (int b = 0; b < 16; b++) begin
      if (msk[b] && cy) begin
        cy = c[b];
        c[b] = !c[b];
      end
    end
    return c;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Either reset idles flags, counters and stored words; this task resets all but m_word
  task automatic model_reset();
    m_irq = '1;
    m_wrap = '1;
    m_awake = '0;
    m_oe_lo = '0;
    m_oe_hi = '0;
    m_cnt = '{default: 0};
    m_mask = '{default: 'hffff};
    m_rd = '{default: 0};
  endtask

  // Clears land before sets, so a set in the same tick wins
  task automatic model_tick(input logic [NPORT-1:0] m);
    int ea[NPORT];
    int j;
    logic [NPORT-1:0] sel, clr, set;
    clr = '0;
    set = '0;
    for (int k = 0; k < NPORT; k++) begin
      sel[k] = !sel_n[k] && sel_hi[k];
      if (m[k]) begin
        ea[k] = !ld_n[k] ? int'(addr[k]) : (!adv_n[k] ? step(m_cnt[k], m_mask[k]) : m_cnt[k]);
        m_wrap[k] = !(ld_n[k] && !adv_n[k] && m_mask[k] != 0 && (ea[k] & m_mask[k]) == 0);
        m_cnt[k] = ea[k];
        if (!mk_n[k]) m_mask[k] = int'(addr[k]);
        m_oe_lo[k] = 1'b0;
        m_oe_hi[k] = 1'b0;
        if (sel[k] && ea[k] >= 'hfffc) begin
          j = 'hffff - ea[k];
          if (rw[k]) begin
            m_rd[k] = m_word[j];
            m_oe_lo[k] = m_awake[k] && !oe_n[k] && !be_lo_n[k];
            m_oe_hi[k] = m_awake[k] && !oe_n[k] && !be_hi_n[k];
            clr[k] = (j == k);
          end else if (j != k) begin
            set[j] = 1'b1;
          end
        end
        m_awake[k] = sel[k];
      end
    end
    m_irq = (m_irq | clr) & ~set;
    // Lowest writer is stored last when several write one mailbox
    for (int k = NPORT - 1; k >= 0; k--) begin
      if (m[k] && sel[k] && !rw[k] && ea[k] >= 'hfffc) begin
        j = 'hffff - ea[k];
        if (!be_lo_n[k]) m_word[j] = (m_word[j] & 'h3fe00) | (int'(wdata[k]) & 'h1ff);
        if (!be_hi_n[k]) m_word[j] = (m_word[j] & 'h1ff) | (int'(wdata[k]) & 'h3fe00);
      end
    end
  endtask

  task automatic cmp_all();
    for (int k = 0; k < NPORT; k++) begin
      chk("mbx_irq_n", 32'(irq_n[k]), 32'(m_irq[k]));
      chk("half_irq_n", 32'(irq_half[k]), 32'(m_irq[k]));
      chk("wrap_irq_n", 32'(wrap_n[k]), 32'(m_wrap[k]));
      chk("awake", 32'(awake[k]), 32'(m_awake[k]));
      chk("count", 32'(cnt[k]), m_cnt[k]);
      chk("rdata", 32'(rdata[k]), m_rd[k]);
      chk("lane_oe", 32'({hi_oe[k], lo_oe[k]}), 32'({m_oe_hi[k], m_oe_lo[k]}));
    end
  endtask

  task automatic acc(input logic [NPORT-1:0] m);
    h.pulse(m);
    model_tick(m);
    cmp_all();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    global_reset_n = 1'b1;
    model_reset();
    m_word = '{default: 0};
    repeat (5) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    cmp_all();
    $display("reset values done");
    // Every writer to every other mailbox; owner clears, sometimes quietly
    for (int j = 0; j < NPORT; j++) begin
      for (int p = 0; p < NPORT; p++) begin
        if (p != j) begin
          h.setp(p, mbx(j), qpm_word_t'(rnd()), 1'b0, 0, 1'b0, 1'b1, p == 3);
          acc(4'(1 << p));
          h.setp(j, mbx(j), '0, 1'b1, 0, 1'b0, 1'b1, (p + j) % 2 == 1);
          acc(4'(1 << j));
        end
      end
    end
    $display("mailbox set and clear done");
    // Own mailbox writes store data but raise nothing
    for (int k = 0; k < NPORT; k++) begin
      h.setp(k, mbx(k), qpm_word_t'(rnd()), 1'b0, 0, 1'b0, 1'b1, 1'b0);
      acc(4'(1 << k));
      h.setp(k, mbx(k), '0, 1'b1, 0, 1'b0, 1'b1, 1'b0);
      acc(4'(1 << k));
    end
    $display("own mailbox done");
    // Either enable off blocks the set and powers the port down
    h.setp(1, mbx(0), qpm_word_t'(rnd()), 1'b0, 1, 1'b0, 1'b1, 1'b0);
    acc(4'b0010);
    h.setp(1, mbx(0), qpm_word_t'(rnd()), 1'b0, 2, 1'b0, 1'b1, 1'b0);
    acc(4'b0010);
    h.setp(1, mbx(0), qpm_word_t'(rnd()), 1'b0, 0, 1'b0, 1'b1, 1'b0);
    acc(4'b0010);
    $display("power down done");
    // Three writers at once, then set against clear in one tick
    for (int p = 1; p < NPORT; p++) begin
      h.setp(p, mbx(0), qpm_word_t'(rnd()), 1'b0, 0, 1'b0, 1'b1, 1'b0);
    end
    acc(4'b1110);
    h.setp(0, mbx(0), '0, 1'b1, 0, 1'b0, 1'b1, 1'b1);
    acc(4'b0011);
    acc(4'b0001);
    // All four read one word in the same tick
    for (int k = 0; k < NPORT; k++) begin
      h.setp(k, mbx(2), '0, 1'b1, 0, 1'b0, 1'b1, 1'b0);
    end
    acc(4'b1111);
    $display("simultaneous access done");
    // Counter steps from the top to zero: one tick of wrap pulse
    for (int k = 0; k < NPORT; k++) begin
      h.setp(k, 16'hffff, '0, 1'b1, 1, 1'b0, 1'b1, 1'b1);
      acc(4'(1 << k));
      h.setp(k, '0, '0, 1'b1, 1, 1'b1, 1'b0, 1'b1);
      acc(4'(1 << k));
      h.setp(k, '0, '0, 1'b1, 1, 1'b1, 1'b1, 1'b1);
      acc(4'(1 << k));
    end
    // Mask keeps seven low bits: the count wraps inside its window
    h.mask_load_n_o[2] = 1'b0;
    h.setp(2, 16'h007f, '0, 1'b1, 1, 1'b1, 1'b1, 1'b1);
    acc(4'b0100);
    h.mask_load_n_o[2] = 1'b1;
    h.setp(2, 16'h357e, '0, 1'b1, 1, 1'b0, 1'b1, 1'b1);
    acc(4'b0100);
    repeat (2) begin
      h.setp(2, '0, '0, 1'b1, 1, 1'b1, 1'b0, 1'b1);
      acc(4'b0100);
    end
    $display("counter wrap done");
    // Global reset in mid-run with a flag pending and counters moved
    h.setp(0, mbx(3), qpm_word_t'(rnd()), 1'b0, 0, 1'b0, 1'b1, 1'b0);
    acc(4'b0001);
    // Top address bit ignored only by the half-deep part
    h.setp(1, 16'h7fff, qpm_word_t'(rnd()), 1'b0, 0, 1'b0, 1'b1, 1'b1);
    h.pulse(4'b0010);
    model_tick(4'b0010);
    chk("half_irq_n", 32'(irq_half[0]), 32'h0);
    chk("mbx_irq_n", 32'(irq_n[0]), 32'(m_irq[0]));
    $display("half-deep match done");
    global_reset_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2 global_reset_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2;
    model_reset();
    cmp_all();
    $display("global reset done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
